//--- common/ldi_pkg.sv
// Shared constants for the LED dimmer target: register map, field layout,
// reset values, selector codes, bus states and dimming timing.
// Assumes a single 250 MHz system clock; no other package is needed.
package ldi_pkg;

    // Register indices carried in the low nibble of the pointer byte
    localparam logic [3:0] REG_PIN_LO   = 4'h0;
    localparam logic [3:0] REG_PIN_HI   = 4'h1;
    localparam logic [3:0] REG_RATE_A   = 4'h2;
    localparam logic [3:0] REG_DUTY_A   = 4'h3;
    localparam logic [3:0] REG_RATE_B   = 4'h4;
    localparam logic [3:0] REG_DUTY_B   = 4'h5;
    localparam logic [3:0] REG_SEL_0_3  = 4'h6;
    localparam logic [3:0] REG_SEL_4_7  = 4'h7;
    localparam logic [3:0] REG_SEL_8_11 = 4'h8;
    localparam logic [3:0] REG_SEL_12_15 = 4'h9;
    localparam logic [3:0] REG_FIRST_RW = 4'h2;
    localparam logic [3:0] REG_LAST     = 4'h9;

    // Pointer byte layout
    localparam int PTR_AUTO_INC_BIT = 4;
    localparam int PTR_INDEX_MSB    = 3;

    // Target address: fixed upper bits, three strap pins below
    localparam logic [3:0] TARGET_ADDR_HI = 4'hc;
    localparam logic       DIR_READ       = 1'b1;
    localparam logic [3:0] BITS_PER_BYTE  = 4'h8;

    // Reset values
    localparam logic [7:0] RATE_RESET = 8'h00;
    localparam logic [7:0] DUTY_RESET = 8'h80;
    localparam logic [7:0] SEL_RESET  = 8'h00;

    // Selector codes, two bits per output
    localparam logic [1:0] SEL_HIZ   = 2'b00;
    localparam logic [1:0] SEL_LOW   = 2'b01;
    localparam logic [1:0] SEL_DIM_A = 2'b10;
    localparam int         LED_COUNT = 16;

    // Synchroniser vector layout
    localparam int          SYNC_W     = 22;
    localparam int          SYNC_SCL   = 21;
    localparam int          SYNC_SDA   = 20;
    localparam int          SYNC_RSTN  = 19;
    localparam int          SYNC_ADDR_SELECT_2  = 18;
    localparam int          SYNC_ADDR_SELECT_0  = 16;
    localparam logic [21:0] SYNC_RESET = 22'h380000;

    // Dimming timing: period = (rate + 1) / 160 s, 256 phase steps per period
    localparam int          CLK_HZ          = 250_000_000;
    localparam int          DIM_PERIOD_DIV  = 160;
    localparam int          DIM_STEPS       = 256;
    localparam int          DIM_TICK_HZ     = DIM_PERIOD_DIV * DIM_STEPS;
    localparam int          DIM_TICK_CYCLES = CLK_HZ / DIM_TICK_HZ;
    localparam logic [7:0]  PHASE_LAST      = 8'(DIM_STEPS - 1);

    // Bus protocol states
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_ADDR  = 3'b001,
        ST_WRITE = 3'b010,
        ST_ACK   = 3'b011,
        ST_READ  = 3'b100,
        ST_RACK  = 3'b101
    } ldi_state_t;

endpackage

//--- sim/ldi_bus_master.sv
// Behavioural I2C master facing the dimmer target.
// Assumes the bench resolves the data wire with a pull-up.
`timescale 1ns/10ps
module ldi_bus_master (
    input  wire logic clk,
    input  wire logic sda,
    output logic      scl,
    output logic      sdaRel
);
    int q = 24; // Quarter bit in clocks; raise it for a slow master

    initial scl = 1'b1;
    initial sdaRel = 1'b1;

    task automatic hold(input int n);
        repeat (n) @(negedge clk);
    endtask
    // Data set only while the clock is low
    task automatic bit_cycle(input logic b, output logic s);
        sdaRel = b;
        hold(q);
        scl = 1'b1;
        hold(q);
        s = sda;
        hold(q);
        scl = 1'b0;
        hold(q);
    endtask
    // Data falls with clock high; also serves as repeated START
    task automatic start();
        sdaRel = 1'b1;
        hold(q);
        scl = 1'b1;
        hold(q);
        sdaRel = 1'b0;
        hold(q);
        scl = 1'b0;
        hold(q);
    endtask
    // Data rises with clock high
    task automatic stop();
        sdaRel = 1'b0;
        hold(q);
        scl = 1'b1;
        hold(q);
        sdaRel = 1'b1;
        hold(q);
    endtask
    // Eight bits MSB first, line released on the ninth pulse
    task automatic send(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_cycle(b[i], s);
        bit_cycle(1'b1, s);
        ack = ~s;
    endtask
    // Receive a byte, then acknowledge or refuse it
    task automatic recv(input logic ackIt, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_cycle(1'b1, s);
            b[i] = s;
        end
        bit_cycle(~ackIt, s);
    endtask
endmodule // ldi_bus_master

//--- sim/ldi_led_dimmer_props.sv
// Pin-level checker for the LED dimmer target.
// Assumes 250 MHz clk and a bus far slower than the synchroniser lag.
`timescale 1ns/10ps
module ldi_led_dimmer_props (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        rstN,
    input wire logic        scl,
    input wire logic        sdaIn,
    input wire logic        sdaOut,
    input wire logic        sdaOe,
    input wire logic [15:0] ledOut,
    input wire logic [15:0] ledOe
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // Open-drain drivers may only pull low
    sda_drive_low_a: assert property (sdaOut == 1'b0) else $error("sdaOut driven high");
    led_drive_low_a: assert property (ledOut == '0) else $error("ledOut driven high");
    // Outputs quiet as reset lifts and once the pin reset is through the synchroniser
    reset_quiet_a: assert property ($fell(rst) |-> !sdaOe && ledOe == '0)
        else $error("outputs active after reset");
    pin_reset_led_a: assert property (!rstN [*6] |-> ledOe == '0) else $error("ledOe active in pin reset");
    pin_reset_sda_a: assert property (!rstN [*4] |-> !sdaOe) else $error("sdaOe active in pin reset");
    // Sync lag lands inside the low half, so data never moves with scl high
    data_stable_a: assert property (scl && $past(scl) |-> $stable(sdaOe))
        else $error("sdaOe moved with scl high");
    ack_hold_a: assert property ($rose(sdaOe) |=> sdaOe [*8]) else $error("sdaOe pulse too short");
    // START from the master meets a released line
    cond_free_a: assert property (scl && $past(scl) && $fell(sdaIn) |-> !sdaOe)
        else $error("sdaOe held at START");

    cover property ($rose(sdaOe));
    cover property ($rose(ledOe[0]));
    cover property (scl && $fell(sdaIn));
endmodule // ldi_led_dimmer_props

bind ldi_led_dimmer ldi_led_dimmer_props ldi_led_dimmer_props_inst (.clk(clk), .rst(rst), .rstN(rstN), .scl(scl),
    .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe), .ledOut(ledOut), .ledOe(ledOe));

//--- sim/test_ldi_led_dimmer.sv
// Self-checking bench for the LED dimmer target, driven over I2C.
// Assumes ldi_bus_master as bus partner and a short dimming tick.
`timescale 1ns/10ps
module test_ldi_led_dimmer;
    localparam int TICK = 4;
    logic             clk = 1'b0;
    logic             rst = 1'b1;
    logic             rstN = 1'b1;
    logic [2:0]       adr = 3'h5;
    logic [15:0]      ledExt = 16'ha5c3;
    logic [15:0]      ledOut;
    logic [15:0]      ledOe;
    logic             scl;
    logic             sdaRel;
    logic             sdaOe;
    logic [7:0]       rb [0:11];
    logic [7:0]       wb [0:3];
    logic [7:0]       dflt [0:9] = '{8'hc3, 8'ha5, 8'h00, 8'h80, 8'h00, 8'h80, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [7:0]       back [0:7] = '{8'h01, 8'h80, 8'h00, 8'h80, 8'h05, 8'h00, 8'h11, 8'h44};
    int               n_fail = 0;
    int               checks = 0;
    int               cycles = 0;
    wire logic        sda = sdaRel & ~sdaOe;
    wire logic [15:0] ledIn = ledExt & ~ledOe;

    always #2 clk = ~clk;

    ldi_led_dimmer #(.TICK_CYCLES(TICK)) ldi_led_dimmer_inst (.clk(clk), .rst(rst), .rstN(rstN), .scl(scl),
        .sdaIn(sda), .sdaOut(), .sdaOe(sdaOe), .addrSelect0(adr[0]), .addrSelect1(adr[1]),
        .addrSelect2(adr[2]), .ledIn(ledIn), .ledOut(ledOut), .ledOe(ledOe));
    ldi_bus_master ldi_bus_master_inst (.clk(clk), .sda(sda), .scl(scl), .sdaRel(sdaRel));

    task automatic chk(input string name, input logic [15:0] e, input logic [15:0] g);
        checks++;
        if (g !== e) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", name, e, g);
        end
    endtask
    task automatic finish_test();
        if (n_fail == 0 && checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // Every byte the target receives must be acknowledged
    task automatic put(input logic [7:0] b);
        logic a;
        ldi_bus_master_inst.send(b, a);
        chk("ack", 16'h1, {15'h0, a});
    endtask
    task automatic wr(input logic [7:0] ptr, input int n);
        ldi_bus_master_inst.start();
        put({ldi_pkg::TARGET_ADDR_HI, adr, 1'b0});
        put(ptr);
        for (int i = 0; i < n; i++) put(wb[i]);
        ldi_bus_master_inst.stop();
    endtask
    // Pointer write, repeated START, n bytes with the last refused
    task automatic rd(input logic [7:0] ptr, input int n);
        ldi_bus_master_inst.start();
        put({ldi_pkg::TARGET_ADDR_HI, adr, 1'b0});
        put(ptr);
        ldi_bus_master_inst.start();
        put({ldi_pkg::TARGET_ADDR_HI, adr, 1'b1});
        for (int i = 0; i < n; i++) ldi_bus_master_inst.recv(i < n - 1, rb[i]);
        ldi_bus_master_inst.stop();
    endtask
    // Cycles an output holds level v, bounded
    task automatic run(input int k, input logic v, output int n);
        n = 0;
        while (ledOe[k] === v && n < 5000) begin
            @(negedge clk);
            n++;
        end
    endtask
    task automatic meas(input int k, output int hi, output int per);
        int x;
        run(k, 1'b1, x);
        run(k, 1'b0, x);
        run(k, 1'b1, hi);
        run(k, 1'b0, x);
        per = hi + x;
    endtask

    // Hang guard well above the expected run length
    always @(posedge clk) begin
        cycles++;
        if (cycles == 95000) begin
            n_fail++;
            finish_test();
        end
    end

    initial begin
        logic ak;
        int   hi;
        int   per;
        repeat (16) @(negedge clk);
        rst = 1'b0;
        repeat (8) @(negedge clk);
        // Defaults, live pins and read wrap back to the status pair
        rd(8'h10, 12);
        for (int i = 0; i < 12; i++) chk("read", {8'h0, dflt[i % 10]}, rb[i]);
        wb = '{8'h11, 8'h44, 8'h01, 8'h00};
        wr(8'h18, 3);
        // Slow master: repeated data without increment, status write dropped
        ldi_bus_master_inst.q = 40;
        wb = '{8'h55, 8'h05, 8'h00, 8'h00};
        wr(8'h06, 2);
        wb[0] = 8'hff;
        wr(8'h00, 1);
        ldi_bus_master_inst.q = 24;
        chk("steady leds", 16'ha503, ledOe);
        rd(8'h12, 8);
        for (int i = 0; i < 8; i++) chk("readback", {8'h0, back[i]}, rb[i]);
        rd(8'h00, 2);
        for (int i = 0; i < 2; i++) chk("pins no inc", 16'h00c0, rb[i]);
        // Pin reset mid-run restores defaults
        rstN = 1'b0;
        repeat (8) @(negedge clk);
        rstN = 1'b1;
        repeat (8) @(negedge clk);
        chk("leds after pin reset", 16'h0, ledOe);
        rd(8'h06, 1);
        chk("selector after pin reset", 16'h0, rb[0]);
        // Each strap setting answers its own address and refuses the next one up
        for (int a = 0; a < 8; a++) begin
            adr = 3'(a);
            repeat (8) @(negedge clk);
            ldi_bus_master_inst.start();
            ldi_bus_master_inst.send({ldi_pkg::TARGET_ADDR_HI, 3'(a + 1), 1'b0}, ak);
            chk("foreign addr", 16'h0, {15'h0, ak});
            ldi_bus_master_inst.start();
            put({ldi_pkg::TARGET_ADDR_HI, 3'(a), 1'b0});
            ldi_bus_master_inst.stop();
        end
        // Two channels: period 256*(rate+1) ticks, on for duty*(rate+1) ticks
        wb = '{8'h00, 8'h40, 8'h01, 8'h20};
        wr(8'h12, 4);
        wb[0] = 8'h0e;
        wr(8'h06, 1);
        meas(0, hi, per);
        chk("dim a on", 16'(64 * TICK), 16'(hi));
        chk("dim a period", 16'(256 * TICK), 16'(per));
        meas(1, hi, per);
        chk("dim b on", 16'(64 * TICK), 16'(hi));
        chk("dim b period", 16'(512 * TICK), 16'(per));
        finish_test();
    end
endmodule // test_ldi_led_dimmer

//--- src/ldi_dim_channel.sv
// One dimming channel: prescaled phase counter and duty compare.
// Assumes a one-cycle tick at 256 * 160 Hz from the parent.
`timescale 1ns/10ps
module ldi_dim_channel (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       tick,
    input  wire logic [7:0] rateDiv,
    input  wire logic [7:0] dutyLevel,
    output logic            dimOn
);

    logic [7:0] rateLat_q;
    logic [7:0] dutyLat_q;
    logic [7:0] preCnt_q;
    logic [7:0] phase_q;

    // Phase advances every rate+1 ticks, 256 steps make one period
    always_ff @(posedge clk) begin
        if (rst) begin
            rateLat_q <= ldi_pkg::RATE_RESET;
            dutyLat_q <= ldi_pkg::DUTY_RESET;
            preCnt_q  <= 8'h00;
            phase_q   <= 8'h00;
        end else if (tick) begin
            if (preCnt_q == rateLat_q) begin
                preCnt_q <= 8'h00;
                phase_q  <= phase_q + 8'h01;
                // New settings only at the period boundary, so no runt pulse
                if (phase_q == ldi_pkg::PHASE_LAST) begin
                    rateLat_q <= rateDiv;
                    dutyLat_q <= dutyLevel;
                end
            end else begin
                preCnt_q <= preCnt_q + 8'h01;
            end
        end
    end

    // On for duty/256 of the period
    always_ff @(posedge clk) begin
        if (rst) begin
            dimOn <= 1'b0;
        end else begin
            dimOn <= (phase_q < dutyLat_q);
        end
    end

endmodule // ldi_dim_channel

//--- src/ldi_led_dimmer.sv
// Sixteen-output LED switch with two dimming channels behind an I2C target.
// Assumes scl/sda and all pins arrive asynchronously; the board resolves the
// open-drain wires from the enables. Clock is 250 MHz, reset synchronous high.
`timescale 1ns/10ps
module ldi_led_dimmer #(
    parameter int unsigned TICK_CYCLES = ldi_pkg::DIM_TICK_CYCLES
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        rstN,
    input  wire logic        scl,
    input  wire logic        sdaIn,
    output logic             sdaOut,
    output logic             sdaOe,
    input  wire logic        addrSelect0,
    input  wire logic        addrSelect1,
    input  wire logic        addrSelect2,
    input  wire logic [15:0] ledIn,
    output logic      [15:0] ledOut,
    output logic      [15:0] ledOe
);

    logic [ldi_pkg::SYNC_W-1:0] syncA_q;
    logic [ldi_pkg::SYNC_W-1:0] syncB_q;
    logic                       sclS;
    logic                       sdaS;
    logic                       localReset;
    logic [2:0]                 addrS;
    logic [15:0]                ledS;
    logic                       sclPrev_q;
    logic                       sdaPrev_q;
    logic                       sclRise;
    logic                       sclFall;
    logic                       startCond;
    logic                       stopCond;
    logic                       byteEnd;
    ldi_pkg::ldi_state_t        state_q;
    logic [3:0]                 bitCnt_q;
    logic [7:0]                 rxShift_q;
    logic [7:0]                 txShift_q;
    logic                       readDir_q;
    logic                       ptrLoaded_q;
    logic [3:0]                 regPtr_q;
    logic                       autoInc_q;
    logic                       sdaOe_q;
    logic                       sdaOut_q;
    logic [7:0]                 regFile_q [ldi_pkg::REG_FIRST_RW:ldi_pkg::REG_LAST];
    logic                       ptrWritable;
    logic                       addrMatch;
    logic                       wrStrobe;
    logic [7:0]                 readData;
    logic [3:0]                 nextWrPtr;
    logic [3:0]                 nextRdPtr;
    logic [15:0]                tickCnt_q;
    logic                       dimTick_q;
    logic                       dimA;
    logic                       dimB;
    logic [31:0]                selAll;
    logic [15:0]                ledOe_q;
    logic [15:0]                ledOut_q;

    // Two-flop synchronisers for every pin; only stage B is looked at
    always_ff @(posedge clk) begin
        if (rst) begin
            syncA_q <= ldi_pkg::SYNC_RESET;
            syncB_q <= ldi_pkg::SYNC_RESET;
        end else begin
            syncA_q <= {scl, sdaIn, rstN, addrSelect2, addrSelect1, addrSelect0, ledIn};
            syncB_q <= syncA_q;
        end
    end

    assign sclS  = syncB_q[ldi_pkg::SYNC_SCL];
    assign sdaS  = syncB_q[ldi_pkg::SYNC_SDA];
    assign addrS = syncB_q[ldi_pkg::SYNC_ADDR_SELECT_2:ldi_pkg::SYNC_ADDR_SELECT_0];
    assign ledS  = syncB_q[15:0];

    // Pin reset holds everything but the synchronisers at defaults while low
    assign localReset = rst | ~syncB_q[ldi_pkg::SYNC_RSTN];

    // Previous bus levels for edge and condition detection
    always_ff @(posedge clk) begin
        if (localReset) begin
            sclPrev_q <= 1'b1;
            sdaPrev_q <= 1'b1;
        end else begin
            sclPrev_q <= sclS;
            sdaPrev_q <= sdaS;
        end
    end

    // Bus events; sda moving while scl high is a condition, never data
    assign sclRise   = sclS & ~sclPrev_q;
    assign sclFall   = ~sclS & sclPrev_q;
    assign startCond = sclS & sclPrev_q & sdaPrev_q & ~sdaS;
    assign stopCond  = sclS & sclPrev_q & ~sdaPrev_q & sdaS;
    assign byteEnd   = sclFall & (bitCnt_q == ldi_pkg::BITS_PER_BYTE);

    // Address compare: fixed upper bits, strap pins below, then direction
    assign addrMatch = (rxShift_q[7:1] == {ldi_pkg::TARGET_ADDR_HI, addrS});

    assign ptrWritable = (regPtr_q >= ldi_pkg::REG_FIRST_RW) && (regPtr_q <= ldi_pkg::REG_LAST);

    // Wrap points differ: writes skip the read-only pair
    assign nextWrPtr = (regPtr_q >= ldi_pkg::REG_LAST) ? ldi_pkg::REG_FIRST_RW
                                                       : regPtr_q + 4'h1;
    assign nextRdPtr = (regPtr_q >= ldi_pkg::REG_LAST) ? ldi_pkg::REG_PIN_LO
                                                       : regPtr_q + 4'h1;

    // Data byte lands at the scl fall after the eighth bit, as the ack starts; pointer byte is never written as data
    assign wrStrobe = (state_q == ldi_pkg::ST_WRITE) & byteEnd & ptrLoaded_q & ptrWritable;

    // Read mux: live pin levels for the two status registers
    always_comb begin
        case (regPtr_q)
            ldi_pkg::REG_PIN_LO: readData = ledS[7:0];
            ldi_pkg::REG_PIN_HI: readData = ledS[15:8];
            default: begin
                if (ptrWritable) begin
                    readData = regFile_q[regPtr_q];
                end else begin
                    readData = 8'h00;
                end
            end
        endcase
    end

    // Bus protocol engine: samples on scl rise, moves sda only after scl fall
    always_ff @(posedge clk) begin
        if (localReset) begin
            state_q     <= ldi_pkg::ST_IDLE;
            bitCnt_q    <= 4'h0;
            rxShift_q   <= 8'h00;
            txShift_q   <= 8'h00;
            readDir_q   <= 1'b0;
            ptrLoaded_q <= 1'b0;
            regPtr_q    <= 4'h0;
            autoInc_q   <= 1'b0;
            sdaOe_q     <= 1'b0;
        end else if (stopCond) begin
            state_q <= ldi_pkg::ST_IDLE;
            sdaOe_q <= 1'b0;
        end else if (startCond) begin
            // A repeated start restarts addressing; the pointer survives
            state_q     <= ldi_pkg::ST_ADDR;
            bitCnt_q    <= 4'h0;
            ptrLoaded_q <= 1'b0;
            sdaOe_q     <= 1'b0;
        end else begin
            case (state_q)
                ldi_pkg::ST_IDLE: begin
                    sdaOe_q <= 1'b0;
                end
                ldi_pkg::ST_ADDR, ldi_pkg::ST_WRITE: begin
                    if (sclRise && (bitCnt_q != ldi_pkg::BITS_PER_BYTE)) begin
                        rxShift_q <= {rxShift_q[6:0], sdaS};
                        bitCnt_q  <= bitCnt_q + 4'h1;
                    end else if (byteEnd) begin
                        bitCnt_q <= 4'h0;
                        if (state_q == ldi_pkg::ST_ADDR) begin
                            if (addrMatch) begin
                                readDir_q <= rxShift_q[0];
                                sdaOe_q   <= 1'b1;
                                state_q   <= ldi_pkg::ST_ACK;
                            end else begin
                                state_q <= ldi_pkg::ST_IDLE;
                            end
                        end else begin
                            // Every written byte is acknowledged, even if dropped
                            sdaOe_q <= 1'b1;
                            state_q <= ldi_pkg::ST_ACK;
                            if (!ptrLoaded_q) begin
                                regPtr_q    <= rxShift_q[ldi_pkg::PTR_INDEX_MSB:0];
                                autoInc_q   <= rxShift_q[ldi_pkg::PTR_AUTO_INC_BIT];
                                ptrLoaded_q <= 1'b1;
                            end else if (autoInc_q) begin
                                regPtr_q <= nextWrPtr;
                            end
                            // Without increment the pointer stays put
                        end
                    end
                end
                ldi_pkg::ST_ACK, ldi_pkg::ST_RACK: begin
                    if ((state_q == ldi_pkg::ST_RACK) && sclRise && sdaS) begin
                        // Master declined more data; wait for stop or start
                        state_q <= ldi_pkg::ST_IDLE;
                    end else if (sclFall) begin
                        if (readDir_q == ldi_pkg::DIR_READ) begin
                            txShift_q <= {readData[6:0], 1'b0};
                            sdaOe_q   <= ~readData[7];
                            bitCnt_q  <= 4'h0;
                            state_q   <= ldi_pkg::ST_READ;
                            if (autoInc_q) begin
                                regPtr_q <= nextRdPtr;
                            end
                        end else begin
                            sdaOe_q <= 1'b0;
                            state_q <= ldi_pkg::ST_WRITE;
                        end
                    end
                end
                ldi_pkg::ST_READ: begin
                    if (sclRise) begin
                        bitCnt_q <= bitCnt_q + 4'h1;
                    end else if (sclFall) begin
                        if (bitCnt_q == ldi_pkg::BITS_PER_BYTE) begin
                            // Release for the master's acknowledge
                            sdaOe_q <= 1'b0;
                            state_q <= ldi_pkg::ST_RACK;
                        end else begin
                            sdaOe_q   <= ~txShift_q[7];
                            txShift_q <= {txShift_q[6:0], 1'b0};
                        end
                    end
                end
                default: begin
                    state_q <= ldi_pkg::ST_IDLE;
                    sdaOe_q <= 1'b0;
                end
            endcase
        end
    end

    // Writable registers; the read-only pair has no storage at all
    always_ff @(posedge clk) begin
        if (localReset) begin
            regFile_q[ldi_pkg::REG_RATE_A]    <= ldi_pkg::RATE_RESET;
            regFile_q[ldi_pkg::REG_DUTY_A]    <= ldi_pkg::DUTY_RESET;
            regFile_q[ldi_pkg::REG_RATE_B]    <= ldi_pkg::RATE_RESET;
            regFile_q[ldi_pkg::REG_DUTY_B]    <= ldi_pkg::DUTY_RESET;
            regFile_q[ldi_pkg::REG_SEL_0_3]   <= ldi_pkg::SEL_RESET;
            regFile_q[ldi_pkg::REG_SEL_4_7]   <= ldi_pkg::SEL_RESET;
            regFile_q[ldi_pkg::REG_SEL_8_11]  <= ldi_pkg::SEL_RESET;
            regFile_q[ldi_pkg::REG_SEL_12_15] <= ldi_pkg::SEL_RESET;
        end else if (wrStrobe) begin
            regFile_q[regPtr_q] <= rxShift_q;
        end
    end

    // Base tick at 256 * 160 Hz shared by both channels
    always_ff @(posedge clk) begin
        if (localReset) begin
            tickCnt_q <= 16'h0000;
            dimTick_q <= 1'b0;
        end else if (tickCnt_q == 16'(TICK_CYCLES - 1)) begin
            tickCnt_q <= 16'h0000;
            dimTick_q <= 1'b1;
        end else begin
            tickCnt_q <= tickCnt_q + 16'h0001;
            dimTick_q <= 1'b0;
        end
    end

    // Channel a from the first rate/duty pair
    ldi_dim_channel u_dimA (
        .clk       (clk),
        .rst       (localReset),
        .tick      (dimTick_q),
        .rateDiv   (regFile_q[ldi_pkg::REG_RATE_A]),
        .dutyLevel (regFile_q[ldi_pkg::REG_DUTY_A]),
        .dimOn     (dimA)
    );

    // Channel b from the second rate/duty pair
    ldi_dim_channel u_dimB (
        .clk       (clk),
        .rst       (localReset),
        .tick      (dimTick_q),
        .rateDiv   (regFile_q[ldi_pkg::REG_RATE_B]),
        .dutyLevel (regFile_q[ldi_pkg::REG_DUTY_B]),
        .dimOn     (dimB)
    );

    // Two selector bits per output, outputs 0-15 from low to high
    assign selAll = {regFile_q[ldi_pkg::REG_SEL_12_15], regFile_q[ldi_pkg::REG_SEL_8_11],
                     regFile_q[ldi_pkg::REG_SEL_4_7], regFile_q[ldi_pkg::REG_SEL_0_3]};

    // Output enables: enable means the switch sinks current, LED on
    always_ff @(posedge clk) begin
        if (localReset) begin
            ledOe_q <= 16'h0000;
        end else begin
            for (int i = 0; i < ldi_pkg::LED_COUNT; i++) begin
                case (selAll[2*i +: 2])
                    ldi_pkg::SEL_HIZ:   ledOe_q[i] <= 1'b0;
                    ldi_pkg::SEL_LOW:   ledOe_q[i] <= 1'b1;
                    ldi_pkg::SEL_DIM_A: ledOe_q[i] <= dimA;
                    default:            ledOe_q[i] <= dimB;
                endcase
            end
        end
    end

    // Open-drain drivers only ever pull low; kept as flops for clean outputs
    always_ff @(posedge clk) begin
        if (localReset) begin
            ledOut_q <= 16'h0000;
            sdaOut_q <= 1'b0;
        end else begin
            ledOut_q <= 16'h0000;
            sdaOut_q <= 1'b0;
        end
    end

    assign sdaOut = sdaOut_q;
    assign sdaOe  = sdaOe_q;
    assign ledOut = ledOut_q;
    assign ledOe  = ledOe_q;

endmodule // ldi_led_dimmer
